// ==== pors_pkg.sv ====
// constants and carriers for the power-on reset sequencer
package pors_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned REF_KHZ = 33330;
  // pll lock delay after system reset release
  localparam int unsigned LOCK_US = 9;
  localparam int unsigned LOCK_CYC = LOCK_US * CLK_MHZ;
  // latest allowed lock after system reset release
  localparam int unsigned LOCK_MAX_US = 10;
  localparam int unsigned LOCK_MAX_CYC = LOCK_MAX_US * CLK_MHZ;
  // warm reset minimum hold, least time rounds up
  localparam int unsigned WARM_NS = 500;
  localparam int unsigned WARM_CYC = (WARM_NS * CLK_MHZ + 999) / 1000;
  // watchdog relock hold in reference periods
  localparam int unsigned WDOG_REF = 24;
  localparam int unsigned WDOG_CYC = (WDOG_REF * CLK_MHZ * 1000 + REF_KHZ - 1) / REF_KHZ;
  // refresh counter, one tick per memory clock period
  localparam logic [11:0] REFRESH_RST = 12'h0384;
  localparam int unsigned REF_DIV = (CLK_MHZ * 1000) / REF_KHZ;
  localparam int unsigned SDCLK_DIV = 1;
  localparam int unsigned STRAP_W = 16;

  typedef enum logic [2:0] {
    PORS_COLD, PORS_HOLD, PORS_LOCKING, PORS_RUN, PORS_WDOG
  } pors_state_e;

  typedef struct packed {
    logic pll_locked;
    logic boot_start;
    logic warm_reset;
    logic refresh_req;
  } pors_status_s;
endpackage

// ==== pors_sequencer.sv ====
// power-on and warm reset sequencer with pll lock and refresh start
`timescale 1ns/1ps
module pors_sequencer
  import pors_pkg::*;
#(
  parameter int unsigned STRAP_WIDTH = STRAP_W
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_power_on_reset_n,
  input wire logic i_system_reset_n,
  input wire logic i_watchdog_event,
  input wire logic i_refresh_disable,
  input wire logic [STRAP_WIDTH-1:0] i_expansion_address_straps,
  output logic o_pll_locked,
  output logic o_boot_start,
  output logic o_warm_reset,
  output logic o_sdram_clk,
  output logic o_refresh_req,
  output logic [STRAP_WIDTH-1:0] o_config_straps,
  output pors_status_s o_status
);
  pors_state_e state_q;
  logic [15:0] cnt_q;
  logic [15:0] low_q;
  logic sys_q;
  logic cold_q;
  logic [11:0] rfc_q;
  logic first_done_q;
  logic en_refresh_q;
  logic sdclk_q;
  logic [STRAP_WIDTH-1:0] straps_q;
  logic pll_q;
  logic boot_q;
  logic warm_q;
  logic rreq_q;

  wire sys_rise = i_system_reset_n && !sys_q;
  // one enable per memory clock period
  wire rfc_tick = sdclk_q;

  // sequencing; lock drop is immediate via combinational gating
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= PORS_COLD;
      cnt_q <= 16'h0000;
      pll_q <= 1'b0;
      boot_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      if (!i_power_on_reset_n || !i_system_reset_n) begin
        state_q <= PORS_HOLD;
        pll_q <= 1'b0;
        cnt_q <= 16'h0000;
      end else if (i_watchdog_event) begin
        state_q <= PORS_WDOG;
        pll_q <= 1'b0;
        cnt_q <= 16'h0000;
      end else begin
        unique case (state_q)
          PORS_COLD, PORS_HOLD: begin
            state_q <= PORS_LOCKING;
            cnt_q <= 16'h0000;
          end
          PORS_LOCKING: begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'(LOCK_CYC - 1)) begin
              state_q <= PORS_RUN;
              pll_q <= 1'b1;
              boot_q <= 1'b1;
            end
          end
          PORS_WDOG: begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'(WDOG_CYC - 1)) begin
              state_q <= PORS_RUN;
              pll_q <= 1'b1;
              boot_q <= 1'b1;
            end
          end
          PORS_RUN: cnt_q <= 16'h0000;
        endcase
      end
    end
  end

  // warm reset detection and system reset edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sys_q <= 1'b0;
      low_q <= 16'h0000;
      warm_q <= 1'b0;
      cold_q <= 1'b1;
    end else begin
      sys_q <= i_system_reset_n;
      warm_q <= 1'b0;
      if (!i_power_on_reset_n) begin
        cold_q <= 1'b1;
        low_q <= 16'h0000;
      end else if (!i_system_reset_n) begin
        if (low_q != 16'hffff) low_q <= low_q + 16'h0001;
      end else begin
        if (sys_rise && !cold_q && low_q >= 16'(WARM_CYC)) warm_q <= 1'b1;
        if (sys_rise) cold_q <= 1'b0;
        low_q <= 16'h0000;
      end
    end
  end

  // strap capture at system reset release
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      straps_q <= '0;
    end else if (sys_rise) begin
      straps_q <= i_expansion_address_straps;
    end
  end

  // memory clock runs once power-on reset is released
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sdclk_q <= 1'b0;
    end else if (!i_power_on_reset_n) begin
      sdclk_q <= 1'b0;
    end else begin
      sdclk_q <= ~sdclk_q;
    end
  end

  // refresh counter at memory clock rate, first access about 7 us out
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rfc_q <= REFRESH_RST;
      first_done_q <= 1'b0;
      rreq_q <= 1'b0;
      en_refresh_q <= 1'b1;
    end else begin
      rreq_q <= 1'b0;
      if (!i_system_reset_n) begin
        rfc_q <= REFRESH_RST;
        first_done_q <= 1'b0;
        en_refresh_q <= 1'b1;
      end else begin
        if (first_done_q) en_refresh_q <= !i_refresh_disable;
        if (rfc_tick && en_refresh_q) begin
          if (rfc_q <= 12'h001) begin
            rfc_q <= REFRESH_RST;
            rreq_q <= 1'b1;
            first_done_q <= 1'b1;
          end else begin
            rfc_q <= rfc_q - 12'h001;
          end
        end
      end
    end
  end

  assign o_pll_locked = pll_q && i_power_on_reset_n && i_system_reset_n && !i_watchdog_event;
  assign o_boot_start = boot_q;
  assign o_warm_reset = warm_q;
  assign o_sdram_clk = sdclk_q;
  assign o_refresh_req = rreq_q;
  assign o_config_straps = straps_q;
  assign o_status = '{pll_locked: o_pll_locked, boot_start: boot_q,
                      warm_reset: warm_q, refresh_req: rreq_q};

  // cycles waited for lock with every reset source released
  logic [15:0] lock_wait_q;
  wire lock_wait_clr = !i_power_on_reset_n || !i_system_reset_n || i_watchdog_event
                       || o_pll_locked;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_wait_q <= 16'h0000;
    end else if (lock_wait_clr) begin
      lock_wait_q <= 16'h0000;
    end else if (lock_wait_q != 16'hffff) begin
      lock_wait_q <= lock_wait_q + 16'h0001;
    end
  end

  lock_drop_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!i_system_reset_n || !i_power_on_reset_n || i_watchdog_event) |-> !o_pll_locked)
    else $error("pll lock not dropped");
  lock_time_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    lock_wait_q < 16'(LOCK_MAX_CYC))
    else $error("pll lock late");
  boot_after_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_boot_start |-> $past(state_q) != PORS_HOLD && pll_q)
    else $error("boot before lock");
  wdog_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $fell(i_watchdog_event) && state_q == PORS_WDOG |-> !pll_q [*8])
    else $error("watchdog relock early");
  sdclk_run_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_power_on_reset_n && $past(i_power_on_reset_n) |=> o_sdram_clk != $past(o_sdram_clk))
    else $error("memory clock stalled");
  refresh_rst_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_system_reset_n |=> rfc_q == REFRESH_RST)
    else $error("refresh count not reset");
  refresh_on_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    !first_done_q |-> en_refresh_q)
    else $error("refresh disabled early");
  warm_cause_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_warm_reset |-> $past(low_q) >= 16'(WARM_CYC) && i_power_on_reset_n)
    else $error("spurious warm reset");

  boot_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) o_boot_start);
  warm_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) o_warm_reset);
  refresh_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) o_refresh_req);
  wdog_c: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    state_q == PORS_WDOG ##1 state_q == PORS_RUN);
endmodule

// ==== pors_board_model.sv ====
// board reset generator model driving resets and straps
`timescale 1ns/1ps
module pors_board_model #(
  parameter int unsigned W = 16
) (
  input wire logic i_ref_clk,
  output logic o_power_on_reset_n,
  output logic o_system_reset_n,
  output logic [W-1:0] o_straps
);
  initial begin
    o_power_on_reset_n = 1'b0;
    o_system_reset_n = 1'b0;
    o_straps = '0;
  end
  // cold start: por low 2000 ns, straps 52 ns ahead of system release
  task automatic cold_boot(input logic [W-1:0] straps);
    o_system_reset_n <= 1'b0;
    o_power_on_reset_n <= 1'b0;
    repeat (500) @(posedge i_ref_clk);
    o_power_on_reset_n <= 1'b1;
    o_straps <= straps;
    repeat (13) @(posedge i_ref_clk);
    o_system_reset_n <= 1'b1;
  endtask
  // warm: system low n cycles, por stays high
  task automatic warm_reset(input int n);
    o_system_reset_n <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    o_system_reset_n <= 1'b1;
  endtask
  // straps may move only once lock is up
  task automatic shift_straps();
    o_straps <= ~o_straps;
  endtask
endmodule

// ==== pors_sequencer_tb.sv ====
// self-checking bench for the power-on reset sequencer
`timescale 1ns/1ps
module pors_sequencer_tb;
  import pors_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_watchdog_event = 1'b0;
  logic i_refresh_disable = 1'b0;
  logic por_n, sys_n, o_pll_locked, o_boot_start, o_warm_reset, o_sdram_clk, o_refresh_req;
  logic [STRAP_W-1:0] straps, o_config_straps;
  pors_status_s o_status;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  initial forever #2 i_ref_clk = ~i_ref_clk;
  pors_board_model #(.W(STRAP_W)) i_pors_board_model (.i_ref_clk(i_ref_clk),
    .o_power_on_reset_n(por_n), .o_system_reset_n(sys_n), .o_straps(straps));
  pors_sequencer i_pors_sequencer (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_power_on_reset_n(por_n), .i_system_reset_n(sys_n),
    .i_watchdog_event(i_watchdog_event), .i_refresh_disable(i_refresh_disable),
    .i_expansion_address_straps(straps), .o_pll_locked(o_pll_locked),
    .o_boot_start(o_boot_start), .o_warm_reset(o_warm_reset), .o_sdram_clk(o_sdram_clk),
    .o_refresh_req(o_refresh_req), .o_config_straps(o_config_straps), .o_status(o_status));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait_lock(output int n);
    n = 0;
    while (o_pll_locked !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
  endtask
  task automatic t_cold();
    int n;
    int nr;
    logic c;
    i_pors_board_model.cold_boot(16'h5a3c);
    tick();
    c = !o_sdram_clk;
    tick();
    check("sdram_clk", o_sdram_clk, c);
    check("lock_early", o_pll_locked, 1'b0);
    // n counts edges since the design first saw system reset high
    n = 1;
    nr = -1;
    while (o_pll_locked !== 1'b1 && n < 3000) begin
      if (o_refresh_req === 1'b1 && nr < 0) begin
        nr = n;
        check("status_refresh", o_status.refresh_req, 1'b1);
      end
      tick();
      n++;
    end
    check("first_refresh", nr inside {[1700:1900]}, 1'b1);
    check("lock_time", n inside {[2200:2500]}, 1'b1);
    check("boot_start", o_boot_start, 1'b1);
    check("status_boot", o_status.boot_start, 1'b1);
    check("status_lock", o_status.pll_locked, 1'b1);
    check("straps", o_config_straps, 16'h5a3c);
    i_pors_board_model.shift_straps();
    tick();
    tick();
    check("straps_kept", o_config_straps, 16'h5a3c);
    $display("test cold done");
  endtask
  task automatic t_warm(input int hold, input logic exp);
    int n;
    logic seen;
    logic seen_s;
    seen = 1'b0;
    seen_s = 1'b0;
    fork
      i_pors_board_model.warm_reset(hold);
      begin
        tick();
        tick();
        check("lock_drop_sys", o_pll_locked, 1'b0);
      end
    join
    repeat (4) begin
      tick();
      seen = seen | o_warm_reset;
      seen_s = seen_s | o_status.warm_reset;
    end
    check("warm_pulse", seen, exp);
    check("status_warm", seen_s, exp);
    wait_lock(n);
    check("relock_time", n inside {[2200:2500]}, 1'b1);
    $display("test warm %0d done", hold);
  endtask
  task automatic t_wdog();
    int n;
    i_watchdog_event <= 1'b1;
    tick();
    tick();
    check("lock_drop_wdog", o_pll_locked, 1'b0);
    i_watchdog_event <= 1'b0;
    wait_lock(n);
    check("wdog_hold", n inside {[170:200]}, 1'b1);
    $display("test watchdog done");
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    i_refresh_disable <= 1'b1;
    tick();
    t_cold();
    t_warm(130, 1'b1);
    t_warm(110, 1'b0);
    t_wdog();
    summarize();
  end
endmodule
